//--- pkg/ddi_pkg.sv
// Package: constants and types for the digital input decoder
package ddi_pkg;

  // ****************************************************************
  // Register map (byte addresses, one word each)
  // ****************************************************************
  localparam logic [7:0] ADDR_INPUT_A = 8'h00;
  localparam logic [7:0] ADDR_INPUT_B = 8'h04;
  localparam logic [7:0] ADDR_INPUT_C = 8'h08;
  localparam logic [7:0] ADDR_INPUT_D = 8'h0c;
  localparam logic [7:0] ADDR_INPUT_E = 8'h10;
  localparam logic [7:0] ADDR_CONFIG = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_HELD_REF = 8'h1c;
  localparam logic [7:0] ADDR_HELD_OUT = 8'h20;

  // Config register fields
  localparam int CFG_PULSE_OUT_BIT = 0;
  localparam int CFG_CLOSED_LOOP_BIT = 1;
  localparam int CFG_BRAKE_TIME_NZ_BIT = 2;
  localparam int CFG_BRAKE_VOLT_NZ_BIT = 3;

  // ****************************************************************
  // Reset values of function selectors and config register
  // ****************************************************************
  localparam logic [5:0] RST_INPUT_A = 6'h07;
  localparam logic [5:0] RST_INPUT_B = 6'h09;
  localparam logic [5:0] RST_INPUT_C = 6'h03;
  localparam logic [5:0] RST_INPUT_D = 6'h0d;
  localparam logic [5:0] RST_INPUT_E = 6'h00;
  localparam logic [3:0] RST_CONFIG = 4'h0;

  // ****************************************************************
  // Function codes
  // ****************************************************************
  localparam logic [5:0] FN_NONE = 6'h00;
  localparam logic [5:0] FN_CLEAR = 6'h01;
  localparam logic [5:0] FN_FREEWHEEL_N = 6'h02;
  localparam logic [5:0] FN_CLEAR_AND_FREEWHEEL_N = 6'h03;
  localparam logic [5:0] FN_FAST_HALT_N = 6'h04;
  localparam logic [5:0] FN_DIRECT_CURRENT_HALT_N = 6'h05;
  localparam logic [5:0] FN_RAMP_HALT_N = 6'h06;
  localparam logic [5:0] FN_RUN = 6'h07;
  localparam logic [5:0] FN_PULSE_RUN = 6'h08;
  localparam logic [5:0] FN_REVERSE = 6'h09;
  localparam logic [5:0] FN_RUN_REVERSE = 6'h0a;
  localparam logic [5:0] FN_RUN_CW = 6'h0b;
  localparam logic [5:0] FN_RUN_CCW = 6'h0c;
  localparam logic [5:0] FN_INCHING = 6'h0d;
  localparam logic [5:0] FN_HOLD_REF = 6'h0e;
  localparam logic [5:0] FN_HOLD_OUT = 6'h0f;
  localparam logic [5:0] FN_SPEED_INC = 6'h10;
  localparam logic [5:0] FN_SPEED_DEC = 6'h11;
  localparam logic [5:0] FN_TRIM_UP = 6'h13;
  localparam logic [5:0] FN_TRIM_DOWN = 6'h14;
  localparam logic [5:0] FN_RAMP_SEL = 6'h15;
  localparam logic [5:0] FN_PRESET_LO = 6'h16;
  localparam logic [5:0] FN_PRESET_HI = 6'h17;
  localparam logic [5:0] FN_PRESET_ON = 6'h18;
  localparam logic [5:0] FN_ACCURATE_HALT_N = 6'h1a;
  localparam logic [5:0] FN_ACCURATE_RUN = 6'h1b;
  localparam logic [5:0] FN_PULSE_REF = 6'h1c;
  localparam logic [5:0] FN_PULSE_FB = 6'h1d;
  localparam logic [5:0] FN_PULSE_CNT = 6'h1e;
  localparam logic [5:0] FN_SETUP_LO = 6'h1f;
  localparam logic [5:0] FN_SETUP_HI = 6'h20;
  localparam logic [5:0] FN_CLEAR_AND_RUN = 6'h21;
  localparam logic [5:0] FN_ENC_REF = 6'h22;
  localparam logic [5:0] FN_ENC_FB = 6'h23;
  localparam logic [5:0] FN_ENC_CNT = 6'h24;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ = 125;
  localparam int PULSE_MIN_MS = 14;
  localparam int PULSE_MIN_CYC = PULSE_MIN_MS * 1000 * CLK_MHZ;
  localparam int CNT_W = 21;
  localparam int HELD_W = 16;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef enum logic [1:0] {
    DDI_RAMP_FIRST = 2'b01,
    DDI_RAMP_SECOND = 2'b10
  } ddi_ramp_t;

  typedef struct packed {
    logic run;
    logic reverse;
    logic output_off;
    logic fast_halt;
    logic dc_brake;
    logic ramp_halt;
    logic inching;
    logic cw_only;
    logic ccw_only;
    logic hold_ref;
    logic hold_out;
    logic trim_up;
    logic trim_down;
    logic ramp_second;
    logic preset_on;
    logic [1:0] preset_idx;
    logic [1:0] setup_idx;
    logic accurate_run;
  } ddi_cmd_t;

endpackage

//--- src/ddi_decoder.sv
// Digital command input decoder with AXI4-Lite function selectors
//
// Overview of operation
// [RULE1] Each of five inputs has a selector; codes 0..36, 18 and 25 unused.
// [RULE2] Encoder codes 34..36 only on inputs D and E, same behaviour.
// [RULE3] Input D refuses pulse codes 28, 29 while pulse output configured.
// [RULE4] Code 0 input has no effect at all.
// [RULE5] Clear code clears alarm on rising edge; lock alarms stay set.
// [RULE6] Freewheel-low switches output stage off immediately.
// [RULE7] Clear-and-freewheel coasts while low, clears on falling edge.
// [RULE8] Fast-halt low ramps down with fast-stop ramp.
// [RULE9] DC brake low brakes only if brake time and voltage nonzero.
// [RULE10] Ramp-halt low decelerates on the selected ramp.
// [RULE11] Level run: high runs, low stops.
// [RULE12] Pulse run needs 14 ms high; latches until a stop.
// [RULE13] Reverse flips direction, never starts, ignored in closed loop.
// [RULE14] Run-reverse starts and reverses together; ignored in closed loop.
// [RULE15] Clockwise-only and anticlockwise-only runs restrict direction.
// [RULE16] Inching forces inching speed, blocked by freewheel, fast or DC halt.
// [RULE17] Reference hold latches reference; kept across stop and power loss.
// [RULE18] Output hold latches output frequency; trim via inc/dec only.
// [RULE19] Inc/dec pulse of 14 ms high, 14 ms low changes held value one step.
// [RULE20] Two preset-select bits form index high/low into four presets.
// [RULE21] Ramp select low picks first ramp pair, high the second.
// [RULE22] Trim up/down by percentage; down wins when both active.
// [RULE23] All inputs synchronised before decoding and edge detection.
// [RULE24] Any stop command overrides any run command.
`timescale 1ns/100ps

module ddi_decoder (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Command terminals (asynchronous pins)
  input wire logic [4:0] term_in,
  // Alarm status from converter
  input wire logic alarm_active,
  input wire logic alarm_locked,
  // Decoded commands
  output ddi_pkg::ddi_cmd_t cmd,
  output logic alarm_clear,
  output logic [15:0] held_ref,
  output logic [15:0] held_out,
  output logic [4:0] pulse_term_en,
  output logic [4:0] encoder_term_en
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [5:0] fsel [5];
  logic [3:0] cfg;
  logic aw_hold, w_hold;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [4:0] sync1, sync2, last;

  // Legal code check per terminal
  function automatic logic code_ok(input int t, input logic [5:0] c, input logic pulse_out);
    logic ok;
    ok = (c <= ddi_pkg::FN_ENC_CNT) && (c != 6'h12) && (c != 6'h19); // [RULE1]
    if ((c == ddi_pkg::FN_ACCURATE_HALT_N || c == ddi_pkg::FN_ACCURATE_RUN) && t > 1)
      ok = 1'b0;
    if ((c == ddi_pkg::FN_PULSE_REF || c == ddi_pkg::FN_PULSE_FB) && t < 3)
      ok = 1'b0;
    if ((c == ddi_pkg::FN_PULSE_REF || c == ddi_pkg::FN_PULSE_FB) && t == 3 && pulse_out)
      ok = 1'b0; // [RULE3]
    if (c == ddi_pkg::FN_PULSE_CNT && t != 4)
      ok = 1'b0;
    if (c >= ddi_pkg::FN_ENC_REF && t < 3)
      ok = 1'b0; // [RULE2]
    return ok;
  endfunction

  // ****************************************************************
  // AXI4-Lite write
  // ****************************************************************
  assign s_axi_awready = !aw_hold && !s_axi_bvalid;
  assign s_axi_wready = !w_hold && !s_axi_bvalid;
  assign s_axi_bresp = 2'b00;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (aw_hold && w_hold) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Illegal codes are dropped so the selector keeps its old function
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      fsel[0] <= ddi_pkg::RST_INPUT_A;
      fsel[1] <= ddi_pkg::RST_INPUT_B;
      fsel[2] <= ddi_pkg::RST_INPUT_C;
      fsel[3] <= ddi_pkg::RST_INPUT_D;
      fsel[4] <= ddi_pkg::RST_INPUT_E;
      cfg <= ddi_pkg::RST_CONFIG;
    end else if (aw_hold && w_hold && w_strb[0]) begin
      for (int t = 0; t < 5; t++) begin
        if (aw_addr == 8'(t * 4) && code_ok(t, w_data[5:0], cfg[ddi_pkg::CFG_PULSE_OUT_BIT]))
          fsel[t] <= w_data[5:0]; // [RULE1]
      end
      if (aw_addr == ddi_pkg::ADDR_CONFIG) begin
        cfg <= w_data[3:0];
      end
    end
  end

  // ****************************************************************
  // AXI4-Lite read
  // ****************************************************************
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'b00;
      unique case (s_axi_araddr)
        ddi_pkg::ADDR_INPUT_A: s_axi_rdata <= {26'h0, fsel[0]};
        ddi_pkg::ADDR_INPUT_B: s_axi_rdata <= {26'h0, fsel[1]};
        ddi_pkg::ADDR_INPUT_C: s_axi_rdata <= {26'h0, fsel[2]};
        ddi_pkg::ADDR_INPUT_D: s_axi_rdata <= {26'h0, fsel[3]};
        ddi_pkg::ADDR_INPUT_E: s_axi_rdata <= {26'h0, fsel[4]};
        ddi_pkg::ADDR_CONFIG: s_axi_rdata <= {28'h0, cfg};
        ddi_pkg::ADDR_STATUS: s_axi_rdata <= {27'h0, sync2};
        ddi_pkg::ADDR_HELD_REF: s_axi_rdata <= {16'h0, held_ref};
        ddi_pkg::ADDR_HELD_OUT: s_axi_rdata <= {16'h0, held_out};
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // Input synchroniser and edges
  // ****************************************************************

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sync1 <= 5'h1f;
      sync2 <= 5'h1f;
      last <= 5'h1f;
    end else begin
      sync1 <= term_in; // [RULE23]
      sync2 <= sync1;
      last <= sync2;
    end
  end

  // ****************************************************************
  // Per-terminal decode
  // ****************************************************************
  // Each function gathers its terminals into one bit vector
  logic [4:0] f_lvl [37];
  logic [4:0] f_rise [37];
  logic [4:0] f_fall [37];

  for (genvar t = 0; t < 5; t++) begin : g_term
    for (genvar c = 0; c < 37; c++) begin : g_code
      // Code 0 maps to nothing read anywhere [RULE4]
      assign f_lvl[c][t] = (fsel[t] == 6'(c)) && sync2[t];
      assign f_rise[c][t] = (fsel[t] == 6'(c)) && sync2[t] && !last[t];
      assign f_fall[c][t] = (fsel[t] == 6'(c)) && !sync2[t] && last[t];
    end
    assign pulse_term_en[t] = fsel[t] == ddi_pkg::FN_PULSE_REF || fsel[t] == ddi_pkg::FN_PULSE_FB
      || fsel[t] == ddi_pkg::FN_PULSE_CNT;
    assign encoder_term_en[t] = fsel[t] >= ddi_pkg::FN_ENC_REF; // [RULE2]
  end

  // Low-active functions: assigned and low
  // Selectors and levels passed in so each assign re-evaluates when they change
  function automatic logic any_low(input logic [5:0] c, input logic [5:0] sel [5], input logic [4:0] lvl);
    logic r;
    r = 1'b0;
    for (int t = 0; t < 5; t++) r = r | (sel[t] == c && !lvl[t]);
    return r;
  endfunction

  logic closed_loop, freewheel, fast_halt, dc_brake, ramp_halt, any_halt;
  assign closed_loop = cfg[ddi_pkg::CFG_CLOSED_LOOP_BIT];
  assign freewheel = any_low(ddi_pkg::FN_FREEWHEEL_N, fsel, sync2)
    || any_low(ddi_pkg::FN_CLEAR_AND_FREEWHEEL_N, fsel, sync2); // [RULE6] [RULE7]
  assign fast_halt = any_low(ddi_pkg::FN_FAST_HALT_N, fsel, sync2); // [RULE8]
  assign dc_brake = any_low(ddi_pkg::FN_DIRECT_CURRENT_HALT_N, fsel, sync2)
    && cfg[ddi_pkg::CFG_BRAKE_TIME_NZ_BIT] && cfg[ddi_pkg::CFG_BRAKE_VOLT_NZ_BIT]; // [RULE9]
  assign ramp_halt = any_low(ddi_pkg::FN_RAMP_HALT_N, fsel, sync2)
    || any_low(ddi_pkg::FN_ACCURATE_HALT_N, fsel, sync2); // [RULE10]
  assign any_halt = freewheel || fast_halt || dc_brake || ramp_halt;

  // ****************************************************************
  // Pulse run latch, 14 ms qualified
  // ****************************************************************
  logic [ddi_pkg::CNT_W-1:0] prun_cnt;
  logic prun_latched;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      prun_cnt <= '0;
      prun_latched <= 1'b0;
    end else begin
      if (|f_lvl[ddi_pkg::FN_PULSE_RUN] || |f_lvl[ddi_pkg::FN_CLEAR_AND_RUN]) begin
        if (prun_cnt != ddi_pkg::CNT_W'(ddi_pkg::PULSE_MIN_CYC))
          prun_cnt <= prun_cnt + 1'b1;
      end else begin
        prun_cnt <= '0;
      end
      if (any_halt)
        prun_latched <= 1'b0; // [RULE12] [RULE24]
      else if (prun_cnt == ddi_pkg::CNT_W'(ddi_pkg::PULSE_MIN_CYC - 1))
        prun_latched <= 1'b1; // [RULE12]
    end
  end

  // ****************************************************************
  // Alarm clear
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      alarm_clear <= 1'b0;
    end else begin
      // Lock alarms only go with a power cycle
      alarm_clear <= alarm_active && !alarm_locked
        && (|f_rise[ddi_pkg::FN_CLEAR] || |f_fall[ddi_pkg::FN_CLEAR_AND_FREEWHEEL_N]
        || |f_rise[ddi_pkg::FN_CLEAR_AND_RUN]); // [RULE5] [RULE7]
    end
  end

  // ****************************************************************
  // Speed increment/decrement, 14 ms high and low qualified
  // ****************************************************************
  logic inc_lvl, dec_lvl;
  logic [ddi_pkg::CNT_W-1:0] hi_cnt, lo_cnt;
  logic step_armed, step;
  assign inc_lvl = |f_lvl[ddi_pkg::FN_SPEED_INC];
  assign dec_lvl = |f_lvl[ddi_pkg::FN_SPEED_DEC];

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      hi_cnt <= '0;
      lo_cnt <= '0;
      step_armed <= 1'b1;
      step <= 1'b0;
    end else begin
      step <= 1'b0;
      if (inc_lvl || dec_lvl) begin
        lo_cnt <= '0;
        if (hi_cnt != ddi_pkg::CNT_W'(ddi_pkg::PULSE_MIN_CYC))
          hi_cnt <= hi_cnt + 1'b1;
        if (step_armed && hi_cnt == ddi_pkg::CNT_W'(ddi_pkg::PULSE_MIN_CYC - 1)) begin
          step <= 1'b1; // [RULE19]
          step_armed <= 1'b0;
        end
      end else begin
        hi_cnt <= '0;
        if (lo_cnt != ddi_pkg::CNT_W'(ddi_pkg::PULSE_MIN_CYC))
          lo_cnt <= lo_cnt + 1'b1;
        if (lo_cnt == ddi_pkg::CNT_W'(ddi_pkg::PULSE_MIN_CYC - 1))
          step_armed <= 1'b1; // [RULE19]
      end
    end
  end

  // Held values count in 0.1 % or 0.1 Hz units; decrement wins
  logic hold_ref, hold_out;
  assign hold_ref = |f_lvl[ddi_pkg::FN_HOLD_REF];
  assign hold_out = |f_lvl[ddi_pkg::FN_HOLD_OUT];

  // No asynchronous reset: the held reference survives power loss
  always_ff @(posedge ref_clk) begin
    if (step && hold_ref) begin
      if (dec_lvl)
        held_ref <= held_ref - 16'h0001; // [RULE17] [RULE19]
      else
        held_ref <= held_ref + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      held_out <= 16'h0000;
    end else if (step && hold_out) begin
      if (dec_lvl)
        held_out <= held_out - 16'h0001; // [RULE18] [RULE19]
      else
        held_out <= held_out + 16'h0001;
    end
  end

  // ****************************************************************
  // Command outputs
  // ****************************************************************
  ddi_pkg::ddi_cmd_t next_cmd;

  always_comb begin
    logic runrev;
    runrev = |f_lvl[ddi_pkg::FN_RUN_REVERSE] && !closed_loop; // [RULE14]
    next_cmd = '0;
    next_cmd.output_off = freewheel;
    next_cmd.fast_halt = fast_halt;
    next_cmd.dc_brake = dc_brake;
    next_cmd.ramp_halt = ramp_halt;
    next_cmd.cw_only = |f_lvl[ddi_pkg::FN_RUN_CW];
    next_cmd.ccw_only = |f_lvl[ddi_pkg::FN_RUN_CCW]; // [RULE15]
    next_cmd.run = !any_halt && (|f_lvl[ddi_pkg::FN_RUN] || prun_latched || runrev
      || next_cmd.cw_only || next_cmd.ccw_only || |f_lvl[ddi_pkg::FN_ACCURATE_RUN]); // [RULE11] [RULE24]
    next_cmd.reverse = (!closed_loop && |f_lvl[ddi_pkg::FN_REVERSE]) || runrev
      || next_cmd.ccw_only; // [RULE13]
    next_cmd.inching = |f_lvl[ddi_pkg::FN_INCHING] && !freewheel && !fast_halt && !dc_brake; // [RULE16]
    next_cmd.hold_ref = hold_ref;
    next_cmd.hold_out = hold_out;
    next_cmd.trim_down = |f_lvl[ddi_pkg::FN_TRIM_DOWN];
    next_cmd.trim_up = |f_lvl[ddi_pkg::FN_TRIM_UP] && !next_cmd.trim_down; // [RULE22]
    next_cmd.ramp_second = |f_lvl[ddi_pkg::FN_RAMP_SEL]; // [RULE21]
    next_cmd.preset_on = |f_lvl[ddi_pkg::FN_PRESET_ON];
    next_cmd.preset_idx = {|f_lvl[ddi_pkg::FN_PRESET_HI], |f_lvl[ddi_pkg::FN_PRESET_LO]}; // [RULE20]
    next_cmd.setup_idx = {|f_lvl[ddi_pkg::FN_SETUP_HI], |f_lvl[ddi_pkg::FN_SETUP_LO]};
    next_cmd.accurate_run = |f_lvl[ddi_pkg::FN_ACCURATE_RUN];
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn)
      cmd <= '0;
    else
      cmd <= next_cmd;
  end

endmodule

//--- test/ddi_decoder_asserts.sv
// Port checker for the digital input decoder
`timescale 1ns/100ps
module ddi_decoder_asserts (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Register bus
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  input wire logic [1:0] s_axi_bresp,
  // Commands and alarm
  input wire ddi_pkg::ddi_cmd_t cmd,
  input wire logic alarm_clear,
  input wire logic alarm_locked,
  input wire logic [4:0] encoder_term_en,
  input wire logic [4:0] pulse_term_en
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  wire logic halt = cmd.output_off | cmd.fast_halt | cmd.dc_brake | cmd.ramp_halt;
  // ****
  // Properties
  // ****
  property p_stop_wins; halt |-> !cmd.run; endproperty
  a_stop_wins: assert property (p_stop_wins) else $error("run while a stop is active");
  property p_inch_block; cmd.inching |-> !(cmd.output_off || cmd.fast_halt || cmd.dc_brake); endproperty
  a_inch_block: assert property (p_inch_block) else $error("inching during a hard stop");
  property p_trim_down; cmd.trim_down |-> !cmd.trim_up; endproperty
  a_trim_down: assert property (p_trim_down) else $error("trim up beside trim down");
  property p_clear_once; alarm_clear |=> !alarm_clear; endproperty
  a_clear_once: assert property (p_clear_once) else $error("clear longer than one cycle");
  property p_lock_keep; alarm_locked [*2] |-> !alarm_clear; endproperty
  a_lock_keep: assert property (p_lock_keep) else $error("clear on a locked alarm");
  property p_enc_pins; encoder_term_en[2:0] == 3'h0; endproperty
  a_enc_pins: assert property (p_enc_pins) else $error("encoder on a plain input");
  property p_pulse_pins; pulse_term_en[2:0] == 3'h0; endproperty
  a_pulse_pins: assert property (p_pulse_pins) else $error("pulse on a plain input");
  property p_rd_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
  property p_b_okay; s_axi_bvalid |-> s_axi_bresp == 2'h0; endproperty
  a_b_okay: assert property (p_b_okay) else $error("write response not okay");
  c_clear: cover property (alarm_clear);
  c_run: cover property (cmd.run);
  c_coast: cover property (cmd.output_off && !cmd.run);
endmodule

bind ddi_decoder ddi_decoder_asserts u_chk (.ref_clk, .rstn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_bvalid, .s_axi_bresp, .cmd, .alarm_clear, .alarm_locked, .encoder_term_en, .pulse_term_en);

//--- test/ddi_term_ctl.sv
// Model of the controller that drives the command terminals
`timescale 1ns/100ps
module ddi_term_ctl #(
  parameter int MIN_HOLD = 2
) (
  // Clock
  input wire logic ref_clk,
  // Requested and driven levels
  input wire logic [4:0] want,
  output logic [4:0] term_in
);
  int hold_cnt = 0;
  logic [4:0] lvl = 5'h1f;
  assign term_in = lvl;
  // Levels kept a minimum time; a short glitch that arrives while idle is stretched to MIN_HOLD + 1 cycles on the pins
  always @(posedge ref_clk) begin
    if (hold_cnt != 0) hold_cnt <= hold_cnt - 1;
    else if (want != lvl) begin
      lvl <= want;
      hold_cnt <= MIN_HOLD;
    end
  end
endmodule

//--- test/tb_ddi_decoder.sv
// Self-checking bench for the digital input decoder
`timescale 1ns/100ps
module tb_ddi_decoder;
  localparam int HOLD = 2;
  localparam int LIMIT = 8000;
  localparam logic [5:0] RST [5] = '{ddi_pkg::RST_INPUT_A, ddi_pkg::RST_INPUT_B, ddi_pkg::RST_INPUT_C,
    ddi_pkg::RST_INPUT_D, ddi_pkg::RST_INPUT_E};
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic alarm_active = 1'b0, alarm_locked = 1'b0, smp = 1'b0;
  logic [4:0] want = 5'h1f;
  wire logic awready, wready, bvalid, arready, rvalid, alarm_clear;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [4:0] term_in;
  ddi_pkg::ddi_cmd_t cmd, m, v;
  logic [33:0] q_rd [$];
  logic [39:0] q_cmd [$];
  logic [39:0] qc;
  int n_mismatch = 0, checks_done = 0, cyc = 0, n_clr = 0;

  always #4 ref_clk = ~ref_clk;

  ddi_decoder DUT (.ref_clk(ref_clk), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .term_in(term_in),
    .alarm_active(alarm_active), .alarm_locked(alarm_locked), .cmd(cmd), .alarm_clear(alarm_clear),
    .held_ref(), .held_out(), .pulse_term_en(), .encoder_term_en());
  ddi_term_ctl #(.MIN_HOLD(HOLD)) u_term (.ref_clk(ref_clk), .want(want), .term_in(term_in));

  // ****
  // Bus and check tasks
  // ****
  task automatic wr(input logic [7:0] a, input logic [5:0] d);
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= {26'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    q_rd.push_back(e);
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
  endtask

  // Pin to command takes sync plus decode; wait past the model's hold too
  task automatic chk();
    q_cmd.push_back({m, v});
    repeat (HOLD + 6) @(posedge ref_clk);
    smp <= 1'b1;
    @(posedge ref_clk);
    smp <= 1'b0;
  endtask

  task automatic cmp(input logic [39:0] e, input logic [39:0] g);
    checks_done++;
    if (e !== g) begin
      n_mismatch++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic finish_test();
    $display("Counts: checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ****
  // Output watcher and timeout
  // ****
  always @(posedge ref_clk) begin
    if (rvalid && rready) cmp(40'(q_rd.pop_front()), 40'({rresp, rdata}));
    if (smp) begin
      qc = q_cmd.pop_front();
      cmp(40'(qc[19:0]), 40'(qc[39:20] & cmd));
    end
    if (alarm_clear === 1'b1) n_clr++;
    cyc++;
    if (cyc == LIMIT) begin
      n_mismatch++;
      finish_test();
    end
  end

  initial begin
    void'($urandom(16));
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 5; i++) rd(ddi_pkg::ADDR_INPUT_A + 8'(4 * i), {28'h0, RST[i]});
    rd(8'h40, {2'h2, 32'h0});
    rd(ddi_pkg::ADDR_STATUS, 34'h1f);
    rd(ddi_pkg::ADDR_HELD_OUT, 34'h0);
    $display("test reset_values done");
    wr(ddi_pkg::ADDR_INPUT_A, 6'h12);
    rd(ddi_pkg::ADDR_INPUT_A, 34'h7);
    wr(ddi_pkg::ADDR_INPUT_A, ddi_pkg::FN_ENC_REF);
    rd(ddi_pkg::ADDR_INPUT_A, 34'h7);
    wr(ddi_pkg::ADDR_INPUT_D, ddi_pkg::FN_ENC_FB);
    rd(ddi_pkg::ADDR_INPUT_D, {28'h0, ddi_pkg::FN_ENC_FB});
    wr(ddi_pkg::ADDR_CONFIG, 6'h1);
    wr(ddi_pkg::ADDR_INPUT_D, ddi_pkg::FN_PULSE_REF);
    rd(ddi_pkg::ADDR_INPUT_D, {28'h0, ddi_pkg::FN_ENC_FB});
    wr(ddi_pkg::ADDR_CONFIG, 6'h0);
    wr(ddi_pkg::ADDR_INPUT_D, ddi_pkg::FN_PULSE_FB);
    rd(ddi_pkg::ADDR_INPUT_D, {28'h0, ddi_pkg::FN_PULSE_FB});
    $display("test selector_codes done");
    wr(ddi_pkg::ADDR_INPUT_D, ddi_pkg::FN_INCHING);
    wr(ddi_pkg::ADDR_INPUT_A, ddi_pkg::FN_RUN);
    wr(ddi_pkg::ADDR_INPUT_B, ddi_pkg::FN_RAMP_HALT_N);
    m = '0;
    m.run = 1'b1;
    m.ramp_halt = 1'b1;
    v = m;
    v.ramp_halt = 1'b0;
    chk();
    want <= 5'h1d;
    v.run = 1'b0;
    v.ramp_halt = 1'b1;
    chk();
    $display("test run_stop done");
    alarm_active <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      alarm_locked <= k[0];
      n_clr = 0;
      want <= 5'h1b;
      m = '0;
      m.output_off = 1'b1;
      m.inching = 1'b1;
      m.run = 1'b1;
      v = '0;
      v.output_off = 1'b1;
      chk();
      want <= 5'h1f;
      v = m;
      v.output_off = 1'b0;
      chk();
      cmp(40'(k == 0), 40'(n_clr));
    end
    alarm_locked <= 1'b0;
    $display("test coast_clear done");
    // Terminal E keeps code 0; random activity must leave every command alone
    m = '1;
    for (int i = 0; i < 8; i++) begin
      want <= {1'($urandom), 4'hf};
      chk();
    end
    $display("test no_function done");
    wr(ddi_pkg::ADDR_INPUT_A, ddi_pkg::FN_PRESET_LO);
    wr(ddi_pkg::ADDR_INPUT_B, ddi_pkg::FN_PRESET_HI);
    m = '0;
    m.preset_idx = 2'h3;
    v = '0;
    for (int i = 0; i < 4; i++) begin
      want <= {3'h7, 2'(i)};
      v.preset_idx = 2'(i);
      chk();
    end
    wr(ddi_pkg::ADDR_INPUT_A, ddi_pkg::FN_TRIM_UP);
    wr(ddi_pkg::ADDR_INPUT_B, ddi_pkg::FN_TRIM_DOWN);
    want <= 5'h1f;
    m = '0;
    m.trim_up = 1'b1;
    m.trim_down = 1'b1;
    v = '0;
    v.trim_down = 1'b1;
    chk();
    want <= 5'h1d;
    v.trim_up = 1'b1;
    v.trim_down = 1'b0;
    chk();
    $display("test preset_trim done");
    wr(ddi_pkg::ADDR_INPUT_A, ddi_pkg::FN_REVERSE);
    wr(ddi_pkg::ADDR_INPUT_B, ddi_pkg::FN_RAMP_SEL);
    want <= 5'h1f;
    m = '0;
    m.run = 1'b1;
    m.reverse = 1'b1;
    m.ramp_second = 1'b1;
    m.ccw_only = 1'b1;
    v = m;
    v.run = 1'b0;
    v.ccw_only = 1'b0;
    chk();
    wr(ddi_pkg::ADDR_CONFIG, 6'h2);
    v.reverse = 1'b0;
    chk();
    wr(ddi_pkg::ADDR_CONFIG, 6'h0);
    wr(ddi_pkg::ADDR_INPUT_B, ddi_pkg::FN_RUN_CCW);
    want <= 5'h1e;
    v = m;
    v.ramp_second = 1'b0;
    chk();
    $display("test direction done");
    finish_test();
  end
endmodule
